// ==== owpta_host_model.sv ====
module owpta_host_model (
  // Serial link driven by the host
  output logic       scl,
  output logic       link_active,
  output wire logic  sda_in,
  // Device pull-down on the data line
  input  wire logic  sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic host_sda;

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain data wire with pull-up: low if either party pulls it
  assign sda_in = host_sda & ~sda_oe;

  // Link idles with clock high and data released
  initial begin
    scl         = 1'b1;
    link_active = 1'b0;
    host_sda    = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 12 ns bit: data moves only while the clock is low
  task automatic send_bit(input logic b, output logic seen);
    scl = 1'b0;
    #3 host_sda = b;
    #3 scl = 1'b1;
    seen = sda_in;
    #6;
  endtask

  // MSB first
  // Byte plus released acknowledge bit; low on the wire means accepted
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i], s);
    end
    send_bit(1'b1, s);
    ack = ~s;
  endtask

  // Command and control byte in one frame; clock stops between frames
  task automatic frame(input logic [7:0] cmd, input logic [7:0] ctrl,
                       output logic a0, output logic a1);
    link_active = 1'b1;
    #4;
    send_byte(cmd, a0);
    send_byte(ctrl, a1);
    // Trailing fall lets the device release the acknowledge
    scl = 1'b0;
    #6 scl = 1'b1;
    #6 link_active = 1'b0;
    #5;
  endtask
endmodule

// ==== owpta_lut.sv ====
module owpta_lut
  import owpta_pkg::*;
(
  // Slot selection
  input  wire logic [2:0]  sel,
  input  wire logic        od,
  input  wire logic [3:0]  code,
  // Decoded value
  output logic      [19:0] value
);

  ////////////////////////////////////////////////////////////////////////////
  // Clamp a code to a ceiling
  function automatic logic [19:0] clamp(input logic [3:0] c,
                                        input logic [3:0] m);
    clamp = (c > m) ? {16'h0000, m} : {16'h0000, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Fixed table as base plus step times code (code minus one for presence), clamped except reset low; fixed levels for pullup and low recovery codes
  always_comb begin
    logic [3:0] m1;
    m1 = (code == 4'h0) ? 4'h0 : code - 4'h1;
    case (sel)
      OWPTA_SEL_RSTL:
        value = od ? OWPTA_RSTL_OD_BASE + OWPTA_STEP_2US * {16'h0000, code}
                   : OWPTA_RSTL_STD_BASE
                     + OWPTA_RSTL_STD_STEP * {16'h0000, code};
      OWPTA_SEL_MSP:
        value = od ? OWPTA_MSP_OD_BASE
                     + OWPTA_STEP_500NS * clamp(m1, OWPTA_MSP_OD_MAX)
                   : OWPTA_MSP_STD_BASE
                     + OWPTA_STEP_2US * clamp(m1, OWPTA_MSP_STD_MAX);
      OWPTA_SEL_W0L:
        value = od ? OWPTA_W0L_OD_BASE
                     + OWPTA_STEP_500NS * clamp(code, OWPTA_W0L_OD_MAX)
                   : OWPTA_W0L_STD_BASE
                     + OWPTA_STEP_2US * clamp(code, OWPTA_W0L_STD_MAX);
      OWPTA_SEL_REC0:
        value = (code < OWPTA_SPLIT_CODE) ? OWPTA_REC0_SHORT
              : OWPTA_REC0_BASE + OWPTA_REC0_STEP
                * clamp(code - OWPTA_SPLIT_CODE, OWPTA_REC0_MAX);
      OWPTA_SEL_WPU:
        value = (code < OWPTA_SPLIT_CODE) ? OWPTA_WPU_LOW : OWPTA_WPU_HIGH;
      default:
        value = 20'h00000;
    endcase
  end

endmodule

// ==== owpta_pkg.sv ====
package owpta_pkg;

  // Command code and control byte layout
  localparam logic [7:0] OWPTA_CMD_ADJUST  = 8'hC3;
  localparam int         OWPTA_SEL_HI      = 7;
  localparam int         OWPTA_SEL_LO      = 5;
  localparam int         OWPTA_OD_BIT      = 4;
  localparam int         OWPTA_VAL_HI      = 3;
  localparam int         OWPTA_VAL_LO      = 0;

  // Parameter selector codes
  localparam logic [2:0] OWPTA_SEL_RSTL    = 3'h0;
  localparam logic [2:0] OWPTA_SEL_MSP     = 3'h1;
  localparam logic [2:0] OWPTA_SEL_W0L     = 3'h2;
  localparam logic [2:0] OWPTA_SEL_REC0    = 3'h3;
  localparam logic [2:0] OWPTA_SEL_WPU     = 3'h4;

  // Storage slots for the eight stored codes
  localparam int         OWPTA_SLOTS       = 8;
  localparam logic [2:0] OWPTA_SLOT_REC0   = 3'h6;
  localparam logic [2:0] OWPTA_SLOT_WPU    = 3'h7;

  // Bit counter: eight data bits, the ninth clock is the acknowledge
  localparam logic [3:0] OWPTA_ACK_BIT     = 4'h8;
  localparam logic [3:0] OWPTA_LAST_DATA   = 4'h7;

  // Values after reset of each stored code
  localparam logic [3:0] OWPTA_DEF_RSTL_STD = 4'h6;
  localparam logic [3:0] OWPTA_DEF_RSTL_OD  = 4'h6;
  localparam logic [3:0] OWPTA_DEF_MSP_STD  = 4'h6;
  localparam logic [3:0] OWPTA_DEF_MSP_OD   = 4'h6;
  localparam logic [3:0] OWPTA_DEF_W0L_STD  = 4'h6;
  localparam logic [3:0] OWPTA_DEF_W0L_OD   = 4'h6;
  localparam logic [3:0] OWPTA_DEF_REC0     = 4'h6;
  localparam logic [3:0] OWPTA_DEF_WPU      = 4'h6;

  // Table values, times in ns, resistance in ohms
  localparam int         OWPTA_VW          = 20;
  localparam logic [19:0] OWPTA_RSTL_STD_BASE = 20'h6B6C0; // 440000
  localparam logic [19:0] OWPTA_RSTL_STD_STEP = 20'h04E20; // 20000
  localparam logic [19:0] OWPTA_RSTL_OD_BASE  = 20'h0ABE0; // 44000
  localparam logic [19:0] OWPTA_STEP_2US      = 20'h007D0; // 2000
  localparam logic [19:0] OWPTA_STEP_500NS    = 20'h001F4; // 500
  localparam logic [19:0] OWPTA_MSP_STD_BASE  = 20'h0E290; // 58000
  localparam logic [19:0] OWPTA_MSP_OD_BASE   = 20'h0157C; // 5500
  localparam logic [19:0] OWPTA_W0L_STD_BASE  = 20'h0CB20; // 52000
  localparam logic [19:0] OWPTA_W0L_OD_BASE   = 20'h01388; // 5000
  localparam logic [19:0] OWPTA_REC0_SHORT    = 20'h00ABE; // 2750
  localparam logic [19:0] OWPTA_REC0_BASE     = 20'h01482; // 5250
  localparam logic [19:0] OWPTA_REC0_STEP     = 20'h009C4; // 2500
  localparam logic [19:0] OWPTA_WPU_LOW       = 20'h001F4; // 500
  localparam logic [19:0] OWPTA_WPU_HIGH      = 20'h003E8; // 1000

  // Saturation points of the code ramps
  localparam logic [3:0] OWPTA_MSP_STD_MAX  = 4'h9;
  localparam logic [3:0] OWPTA_MSP_OD_MAX   = 4'hB;
  localparam logic [3:0] OWPTA_W0L_STD_MAX  = 4'h9;
  localparam logic [3:0] OWPTA_W0L_OD_MAX   = 4'hA;
  localparam logic [3:0] OWPTA_SPLIT_CODE   = 4'h6;
  localparam logic [3:0] OWPTA_REC0_MAX     = 4'h8;

  // Link-side byte states, Gray coded along the path
  typedef enum logic [1:0] {
    OWPTA_LK_CMD  = 2'h0,
    OWPTA_LK_CTRL = 2'h1,
    OWPTA_LK_DONE = 2'h3
  } owpta_lk_t;

endpackage

// ==== owpta_top.sv ====
// Behaviour
// - Command C3h plus one control byte adjusts one port parameter.
// - Power-up or device reset restores every parameter code to default.
// - Busy at command arrival: no acknowledge for either byte, no change.
// - Control byte captured at rising edge of its acknowledge clock; parameter code written on the third clk edge after.
// - After acceptance the read pointer moves to the port configuration.
// - Control bits 7:5 select the parameter, bit 4 is speed flag.
// - Control bits 3:0 are the value code, decoded by fixed table.
// - Selector 000..100 picks reset, presence, write-zero, recovery, pullup.
// - Reset, presence, write-zero store standard or overdrive by speed flag.
// - Recovery and pullup ignore speed flag, one shared setting.
// - Reset low time 440+20n us standard, 44+2n us overdrive.
// - Presence sample 58/5.5 us, +2/+0.5 per code, saturating 76/11.
// - Write-zero low 52+2n capped 70, overdrive 5+0.5n capped 10.
// - Recovery 2.75 us to code 5, then 5.25 up by 2.5 to 25.25.
module owpta_top
  import owpta_pkg::*;
(
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial link, clocked by its own clock
  input  wire logic        scl,
  input  wire logic        link_active,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Device state and control
  input  wire logic        bus_busy_flag,
  input  wire logic        dev_reset,
  output logic             rd_ptr_port_stb,
  // Stored parameter codes
  output logic      [3:0]  reset_low_time_std_code,
  output logic      [3:0]  reset_low_time_od_code,
  output logic      [3:0]  presence_sample_time_std_code,
  output logic      [3:0]  presence_sample_time_od_code,
  output logic      [3:0]  write_zero_low_time_std_code,
  output logic      [3:0]  write_zero_low_time_od_code,
  output logic      [3:0]  write_zero_recovery_time_code,
  output logic      [3:0]  weak_pullup_resistance_code,
  // Decoded parameter values, ns or ohms
  output logic      [19:0] reset_low_time_std_ns,
  output logic      [19:0] reset_low_time_od_ns,
  output logic      [19:0] presence_sample_time_std_ns,
  output logic      [19:0] presence_sample_time_od_ns,
  output logic      [19:0] write_zero_low_time_std_ns,
  output logic      [19:0] write_zero_low_time_od_ns,
  output logic      [19:0] write_zero_recovery_time_ns,
  output logic      [19:0] weak_pullup_resistance_ohm
);

  ////////////////////////////////////////////////////////////////////////////
  // Slot helpers shared by the write path and the decoders
  function automatic logic [2:0] slot_sel(input int i);
    slot_sel = (i < 6) ? 3'(i / 2) : 3'(i - 3);
  endfunction

  function automatic logic slot_od(input int i);
    slot_od = (i < 6) && (i % 2 == 1);
  endfunction

  function automatic logic [3:0] slot_default(input int i);
    case (i)
      0:       slot_default = OWPTA_DEF_RSTL_STD;
      1:       slot_default = OWPTA_DEF_RSTL_OD;
      2:       slot_default = OWPTA_DEF_MSP_STD;
      3:       slot_default = OWPTA_DEF_MSP_OD;
      4:       slot_default = OWPTA_DEF_W0L_STD;
      5:       slot_default = OWPTA_DEF_W0L_OD;
      6:       slot_default = OWPTA_DEF_REC0;
      default: slot_default = OWPTA_DEF_WPU;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain signals
  owpta_lk_t   lk_state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  byte_nxt;
  logic        busy_s1_r;
  logic        busy_s2_r;
  logic        ack_ok_r;
  logic        sda_oe_r;
  logic [7:0]  ctrl_hold_r;
  logic        wr_tgl_r;

  // System domain signals
  logic        tgl_s1_r;
  logic        tgl_s2_r;
  logic        tgl_s3_r;
  logic        apply_stb;
  logic [2:0]  wr_sel;
  logic        speed_variant_flag;
  logic [3:0]  param_value_code;
  logic        wr_valid;
  logic [2:0]  wr_slot;
  logic        rd_ptr_r;
  logic [3:0]  code_r  [OWPTA_SLOTS];
  logic [19:0] lut_val [OWPTA_SLOTS];
  logic [19:0] value_r [OWPTA_SLOTS];

  assign byte_nxt = {shift_r[6:0], sda_in};

  ////////////////////////////////////////////////////////////////////////////
  // Busy flag into the link domain
  always_ff @(posedge scl) begin
    busy_s1_r <= bus_busy_flag;
    busy_s2_r <= busy_s1_r;
  end

  // Bit counter, nine clocks per byte; the frame signal ends it
  always_ff @(posedge scl or negedge link_active) begin
    if (!link_active) begin
      bit_cnt_r <= 4'h0;
    end else if (bit_cnt_r == OWPTA_ACK_BIT) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Data bits shift in at the rising clock edge
  always_ff @(posedge scl or negedge link_active) begin
    if (!link_active) begin
      shift_r <= 8'h00;
    end else if (bit_cnt_r < OWPTA_ACK_BIT) begin
      shift_r <= byte_nxt;
    end
  end

  // Byte sequencing and acknowledge decision
  always_ff @(posedge scl or negedge link_active) begin
    if (!link_active) begin
      lk_state_r <= OWPTA_LK_CMD;
      ack_ok_r   <= 1'b0;
    end else if (bit_cnt_r == OWPTA_LAST_DATA) begin
      case (lk_state_r)
        OWPTA_LK_CMD: begin
          ack_ok_r <= (byte_nxt == OWPTA_CMD_ADJUST) && !busy_s2_r;
          if (byte_nxt != OWPTA_CMD_ADJUST || busy_s2_r) begin
            lk_state_r <= OWPTA_LK_DONE;
          end
        end
        OWPTA_LK_CTRL: ack_ok_r <= 1'b1;
        OWPTA_LK_DONE: ack_ok_r <= 1'b0;
        default: begin
          lk_state_r <= OWPTA_LK_DONE;
          ack_ok_r   <= 1'b0;
        end
      endcase
    end else if (bit_cnt_r == OWPTA_ACK_BIT) begin
      // Command ack opens the control byte, control ack ends the frame
      ack_ok_r <= 1'b0;
      if (lk_state_r == OWPTA_LK_CMD && ack_ok_r) begin
        lk_state_r <= OWPTA_LK_CTRL;
      end else if (lk_state_r == OWPTA_LK_CTRL) begin
        lk_state_r <= OWPTA_LK_DONE;
      end
    end
  end

  // Acknowledge drive held from falling edge to falling edge
  always_ff @(negedge scl or negedge link_active) begin
    if (!link_active) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= ack_ok_r && (bit_cnt_r == OWPTA_ACK_BIT);
    end
  end

  assign sda_oe  = sda_oe_r;
  assign sda_out = 1'b0;

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      ctrl_hold_r <= 8'h00;
      wr_tgl_r    <= 1'b0;
    end else if (lk_state_r == OWPTA_LK_CTRL
                 && bit_cnt_r == OWPTA_ACK_BIT) begin
      ctrl_hold_r <= shift_r;
      wr_tgl_r    <= ~wr_tgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write event into the system domain
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= wr_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign apply_stb = tgl_s2_r ^ tgl_s3_r;

  assign wr_sel             = ctrl_hold_r[OWPTA_SEL_HI:OWPTA_SEL_LO];
  assign speed_variant_flag = ctrl_hold_r[OWPTA_OD_BIT];
  assign param_value_code   = ctrl_hold_r[OWPTA_VAL_HI:OWPTA_VAL_LO];

  always_comb begin
    wr_valid = 1'b1;
    case (wr_sel)
      OWPTA_SEL_RSTL,
      OWPTA_SEL_MSP,
      OWPTA_SEL_W0L:  wr_slot = {wr_sel[1:0], speed_variant_flag};
      OWPTA_SEL_REC0: wr_slot = OWPTA_SLOT_REC0;
      OWPTA_SEL_WPU:  wr_slot = OWPTA_SLOT_WPU;
      default: begin
        wr_slot  = 3'h0;
        wr_valid = 1'b0;
      end
    endcase
  end

  // Stored codes and decoded values per slot
  for (genvar i = 0; i < OWPTA_SLOTS; i++) begin : g_slot
    always_ff @(posedge clk) begin
      if (rst || dev_reset) begin
        code_r[i] <= slot_default(i);
      end else if (apply_stb && wr_valid && wr_slot == 3'(i)) begin
        code_r[i] <= param_value_code;
      end
    end

    owpta_lut u_lut (
      .sel   (slot_sel(i)),
      .od    (slot_od(i)),
      .code  (code_r[i]),
      .value (lut_val[i])
    );

    always_ff @(posedge clk) begin
      if (rst) begin
        value_r[i] <= 20'h00000;
      end else begin
        value_r[i] <= lut_val[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr_r <= 1'b0;
    end else begin
      rd_ptr_r <= apply_stb;
    end
  end

  assign rd_ptr_port_stb = rd_ptr_r;

  // Output mapping
  assign reset_low_time_std_code       = code_r[0];
  assign reset_low_time_od_code        = code_r[1];
  assign presence_sample_time_std_code = code_r[2];
  assign presence_sample_time_od_code  = code_r[3];
  assign write_zero_low_time_std_code  = code_r[4];
  assign write_zero_low_time_od_code   = code_r[5];
  assign write_zero_recovery_time_code = code_r[6];
  assign weak_pullup_resistance_code   = code_r[7];
  assign reset_low_time_std_ns         = value_r[0];
  assign reset_low_time_od_ns          = value_r[1];
  assign presence_sample_time_std_ns   = value_r[2];
  assign presence_sample_time_od_ns    = value_r[3];
  assign write_zero_low_time_std_ns    = value_r[4];
  assign write_zero_low_time_od_ns     = value_r[5];
  assign write_zero_recovery_time_ns   = value_r[6];
  assign weak_pullup_resistance_ohm    = value_r[7];

  ////////////////////////////////////////////////////////////////////////////
  // Checks in the link domain
  sequence cmd_good_s;
    lk_state_r == OWPTA_LK_CMD && bit_cnt_r == OWPTA_LAST_DATA
      && byte_nxt == OWPTA_CMD_ADJUST && !busy_s2_r;
  endsequence

  sequence cmd_busy_s;
    lk_state_r == OWPTA_LK_CMD && bit_cnt_r == OWPTA_LAST_DATA && busy_s2_r;
  endsequence

  cmd_claim_a: assert property (
    @(posedge scl) disable iff (!link_active)
    cmd_good_s |=> ack_ok_r ##1 lk_state_r == OWPTA_LK_CTRL
  ) else $error("adjust command not claimed");

  busy_refuse_a: assert property (
    @(posedge scl) disable iff (!link_active)
    cmd_busy_s |=> lk_state_r == OWPTA_LK_DONE && !ack_ok_r
      ##1 !ack_ok_r [*8] ##1 !ack_ok_r
  ) else $error("busy command acknowledged");

  ctrl_capture_a: assert property (
    @(posedge scl) disable iff (!link_active || rst)
    cmd_good_s ##9 (bit_cnt_r == OWPTA_LAST_DATA) ##1 1'b1
      |=> $changed(wr_tgl_r) && ctrl_hold_r == $past(shift_r)
  ) else $error("control byte not captured at acknowledge");

  ////////////////////////////////////////////////////////////////////////////
  // Checks in the system domain
  reset_default_a: assert property (
    @(posedge clk) dev_reset |=> code_r[0] == OWPTA_DEF_RSTL_STD
      && code_r[3] == OWPTA_DEF_MSP_OD && code_r[6] == OWPTA_DEF_REC0
      && code_r[7] == OWPTA_DEF_WPU
  ) else $error("defaults not restored");

  ptr_move_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(apply_stb) |=> rd_ptr_port_stb ##1 !rd_ptr_port_stb
  ) else $error("read pointer not moved");

  speed_slot_a: assert property (
    @(posedge clk) disable iff (rst || dev_reset)
    apply_stb && wr_sel == OWPTA_SEL_RSTL && speed_variant_flag
      |=> code_r[1] == $past(param_value_code) && $stable(code_r[0])
  ) else $error("overdrive slot not written");

  shared_slot_a: assert property (
    @(posedge clk) disable iff (rst || dev_reset)
    apply_stb && wr_sel == OWPTA_SEL_REC0
      |=> code_r[6] == $past(param_value_code) && $stable(code_r[1])
  ) else $error("recovery slot not written");

  bad_sel_a: assert property (
    @(posedge clk) disable iff (rst || dev_reset)
    apply_stb && wr_sel > OWPTA_SEL_WPU |=> $stable(code_r[7])
      && $stable(code_r[0])
  ) else $error("unused selector changed a code");

  hold_code_a: assert property (
    @(posedge clk) disable iff (rst || dev_reset)
    !apply_stb && !dev_reset |=> $stable(code_r[2]) && $stable(code_r[5])
  ) else $error("code changed without a write");

  rstl_val_a: assert property (
    @(posedge clk) disable iff (rst)
    !rst |=> reset_low_time_std_ns == OWPTA_RSTL_STD_BASE
      + OWPTA_RSTL_STD_STEP * {16'h0000, $past(code_r[0])}
  ) else $error("reset low value wrong");

  pullup_val_a: assert property (
    @(posedge clk) disable iff (rst)
    !rst |=> weak_pullup_resistance_ohm
      == (($past(code_r[7]) < OWPTA_SPLIT_CODE) ? OWPTA_WPU_LOW
                                                 : OWPTA_WPU_HIGH)
  ) else $error("pullup value wrong");

endmodule

// ==== owpta_top_tb.sv ====
module owpta_top_tb
  import owpta_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst;
  logic        bus_busy_flag;
  logic        dev_reset;
  wire         scl;
  wire         link_active;
  wire         sda_in;
  logic        sda_out;
  logic        sda_oe;
  logic        rd_ptr_port_stb;
  logic [3:0]  codes [8];
  logic [19:0] vals [8];
  logic [3:0]  exp_code [8];
  int          err_total;
  int          samples_checked;
  int          stb_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Design and host model
  owpta_top dut (
    .clk(clk), .rst(rst), .scl(scl), .link_active(link_active),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_busy_flag(bus_busy_flag), .dev_reset(dev_reset),
    .rd_ptr_port_stb(rd_ptr_port_stb),
    .reset_low_time_std_code(codes[0]), .reset_low_time_od_code(codes[1]),
    .presence_sample_time_std_code(codes[2]),
    .presence_sample_time_od_code(codes[3]),
    .write_zero_low_time_std_code(codes[4]),
    .write_zero_low_time_od_code(codes[5]),
    .write_zero_recovery_time_code(codes[6]),
    .weak_pullup_resistance_code(codes[7]),
    .reset_low_time_std_ns(vals[0]), .reset_low_time_od_ns(vals[1]),
    .presence_sample_time_std_ns(vals[2]),
    .presence_sample_time_od_ns(vals[3]),
    .write_zero_low_time_std_ns(vals[4]),
    .write_zero_low_time_od_ns(vals[5]),
    .write_zero_recovery_time_ns(vals[6]),
    .weak_pullup_resistance_ohm(vals[7]));

  owpta_host_model host (
    .scl(scl), .link_active(link_active), .sda_in(sda_in), .sda_oe(sda_oe));

  // Clock and read-pointer strobe counter
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (rd_ptr_port_stb === 1'b1) stb_cnt <= stb_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected table value of slot k for value code c
  function automatic logic [19:0] exp_val(int k, logic [3:0] c);
    int n;
    int v;
    n = c;
    case (k)
      0: v = 440000 + 20000 * n;
      1: v = 44000 + 2000 * n;
      2: v = 58000 + 2000 * (n > 1 ? n - 1 : 0);
      3: v = 5500 + 500 * (n > 1 ? n - 1 : 0);
      4: v = 52000 + 2000 * n;
      5: v = 5000 + 500 * n;
      6: v = (n < 6) ? 2750 : 5250 + 2500 * (n - 6);
      default: v = (n < 6) ? 500 : 1000;
    endcase
    if (k == 2 && v > 76000) v = 76000;
    if (k == 3 && v > 11000) v = 11000;
    if (k == 4 && v > 70000) v = 70000;
    if (k == 5 && v > 10000) v = 10000;
    if (k == 6 && v > 25250) v = 25250;
    return 20'(v);
  endfunction

  // Comparisons, one per kind of result
  task automatic chk_bit(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_code(string nm, logic [3:0] e, logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_val(string nm, logic [19:0] e, logic [19:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // All eight stored codes and decoded values against the model
  task automatic chk_all();
    for (int k = 0; k < 8; k++) begin
      chk_code("stored code", exp_code[k], codes[k]);
      chk_val("value", exp_val(k, exp_code[k]), vals[k]);
    end
  endtask

  // One frame, then bounded wait for the read-pointer strobe
  task automatic adjust(logic [7:0] cmd, logic [7:0] ctrl, logic ok,
                        logic stb);
    logic a0;
    logic a1;
    int   s0;
    s0 = stb_cnt;
    host.frame(cmd, ctrl, a0, a1);
    chk_bit("command ack", ok, a0);
    chk_bit("control ack", ok, a1);
    chk_bit("data drive level", 1'b0, sda_out);
    for (int i = 0; i < 20 && stb_cnt == s0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk_bit("pointer strobe", stb, stb_cnt == s0 + 1);
    if (stb && stb_cnt == s0) test_done();
    chk_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_table();
    int         k;
    logic [7:0] cb;
    for (int s = 0; s < 5; s++) begin
      for (int od = 0; od < 2; od++) begin
        for (int c = 0; c < 16; c++) begin
          k = (s < 3) ? s * 2 + od : s + 3;
          exp_code[k] = 4'(c);
          cb = {3'(s), 1'(od), 4'(c)};
          adjust(OWPTA_CMD_ADJUST, cb, 1'b1, 1'b1);
        end
      end
    end
  endtask

  task automatic t_refuse();
    adjust(8'hE1, 8'h0F, 1'b0, 1'b0);
    bus_busy_flag <= 1'b1;
    repeat (4) @(posedge clk);
    adjust(OWPTA_CMD_ADJUST, 8'h23, 1'b0, 1'b0);
    bus_busy_flag <= 1'b0;
    for (int s = 5; s < 8; s++) begin
      adjust(OWPTA_CMD_ADJUST, {3'(s), 5'h12}, 1'b1, 1'b1);
    end
  endtask

  task automatic t_devreset();
    dev_reset <= 1'b1;
    @(posedge clk);
    dev_reset <= 1'b0;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 8; k++) exp_code[k] = 4'h6;
    chk_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #200000;
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    clk             = 1'b0;
    rst             = 1'b1;
    bus_busy_flag   = 1'b0;
    dev_reset       = 1'b0;
    err_total       = 0;
    samples_checked = 0;
    stb_cnt         = 0;
    for (int k = 0; k < 8; k++) exp_code[k] = 4'h6;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_all();
    t_table();
    t_refuse();
    t_devreset();
    test_done();
  end
endmodule
